// File: design/aod_output_demux.sv
// Output demultiplexer, forwarded data strobe, out-of-range flag and calibration gating.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`include "aod_defines.svh"

module aod_output_demux
  import aod_pkg::*;
(
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_sample_clk,
  input  wire logic [7:0]               i_sample_i,
  input  wire logic [7:0]               i_sample_q,
  input  wire logic signed [11:0]       i_analog_level,
  input  wire logic                     i_demux_mode_pin,
  input  wire logic                     i_ddr_mode_pin,
  input  wire logic                     i_full_scale_select_pin,
  input  wire logic                     i_ext_control_enable_pin_n,
  input  wire logic                     i_cal_request_pin,
  input  wire logic [`AOD_ADDR_W-1:0]   i_reg_addr,
  input  wire logic [`AOD_DATA_W-1:0]   i_reg_wdata,
  input  wire logic                     i_reg_write,
  input  wire logic                     i_reg_read,
  output logic      [`AOD_DATA_W-1:0]   o_reg_rdata,
  output logic      [7:0]               o_i_channel_late_bus,
  output logic      [7:0]               o_q_channel_late_bus,
  output logic      [7:0]               o_i_channel_early_bus,
  output logic      [7:0]               o_q_channel_early_bus,
  output logic                          o_early_bus_oe,
  output logic                          o_forwarded_data_strobe,
  output logic                          o_mirror_data_strobe,
  output logic                          o_out_of_range,
  output logic                          o_irq
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [2:0]  sclk_sync_reg;
  logic [7:0]  si_s1_reg, si_s2_reg, sq_s1_reg, sq_s2_reg;
  logic [11:0] lvl_s1_reg, lvl_s2_reg;
  logic [4:0]  pin_s1_reg, pin_s2_reg;
  logic        cal_pin_d_reg;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sclk_sync_reg <= 3'h0;
      si_s1_reg     <= 8'h00;
      si_s2_reg     <= 8'h00;
      sq_s1_reg     <= 8'h00;
      sq_s2_reg     <= 8'h00;
      lvl_s1_reg    <= 12'h000;
      lvl_s2_reg    <= 12'h000;
      pin_s1_reg    <= 5'h08;
      pin_s2_reg    <= 5'h08;
      cal_pin_d_reg <= 1'b0;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], i_sample_clk};
      si_s1_reg     <= i_sample_i;
      si_s2_reg     <= si_s1_reg;
      sq_s1_reg     <= i_sample_q;
      sq_s2_reg     <= sq_s1_reg;
      lvl_s1_reg    <= i_analog_level;
      lvl_s2_reg    <= lvl_s1_reg;
      pin_s1_reg    <= {i_cal_request_pin, i_ext_control_enable_pin_n, i_full_scale_select_pin,
                        i_ddr_mode_pin, i_demux_mode_pin};
      pin_s2_reg    <= pin_s1_reg;
      cal_pin_d_reg <= pin_s2_reg[4];
    end
  end

  wire sample_evt = sclk_sync_reg[1] & ~sclk_sync_reg[2];

  // ----------------------------------------
  // Registers and effective settings
  // ----------------------------------------
  logic [1:0]             ctrl_reg;
  logic [11:0]            fsadj_reg;
  logic                   trim_skip_reg;
  logic [`AOD_IRQ_W-1:0]  irq_stat_reg, irq_mask_reg;
  logic [`AOD_DATA_W-1:0] rdata_reg;
  aod_cal_state_t         cal_state_reg;

  wire ext_active   = ~pin_s2_reg[3];
  wire demux_eff    = ext_active ? ctrl_reg[`AOD_CTRL_DEMUX_BIT] : pin_s2_reg[0];
  wire ddr_sel      = ext_active ? ctrl_reg[`AOD_CTRL_DDR_BIT] : pin_s2_reg[1];
  wire ddr_eff      = ~demux_eff | ddr_sel;
  wire [11:0] fs_pin_mv = pin_s2_reg[2] ? `AOD_FS_HIGH_MV : `AOD_FS_LOW_MV;
  wire [11:0] fs_mv = ext_active ? fsadj_reg : fs_pin_mv;
  wire trimming     = (cal_state_reg == AOD_CAL_TRIM);
  wire calibrating  = (cal_state_reg != AOD_CAL_IDLE);

  wire wr_ctrl   = i_reg_write & (i_reg_addr == `AOD_OFS_CTRL);
  wire wr_fsadj  = i_reg_write & (i_reg_addr == `AOD_OFS_FSADJ);
  wire wr_mask   = i_reg_write & (i_reg_addr == `AOD_OFS_IRQ_MASK);
  wire wr_ext    = i_reg_write & (i_reg_addr == `AOD_OFS_EXT_CFG);
  wire rd_stat   = i_reg_read & (i_reg_addr == `AOD_OFS_IRQ_STAT);
  wire cal_go    = (wr_ctrl & i_reg_wdata[`AOD_CTRL_CAL_BIT]) | (pin_s2_reg[4] & ~cal_pin_d_reg);

  // ----------------------------------------
  // Out-of-range detection
  // ----------------------------------------
  function automatic logic beyond_half(input logic [11:0] lvl, input logic [11:0] fs);
    logic [12:0] mag;
    mag = lvl[11] ? (13'h0000 - {lvl[11], lvl}) : {1'b0, lvl};
    return ({mag[11:0], 1'b0} > {1'b0, fs});
  endfunction

  wire over_range = beyond_half(lvl_s2_reg, fs_mv);

  // ----------------------------------------
  // Demultiplexer and strobe
  // ----------------------------------------
  logic       phase_reg, strobe_reg, oe_reg, or_reg;
  logic [7:0] hold_i_reg, hold_q_reg, late_i_reg, late_q_reg, early_i_reg, early_q_reg;

  wire out_evt   = sample_evt & ~trimming;
  wire pair_done = demux_eff & phase_reg;
  wire word_upd  = out_evt & (pair_done | ~demux_eff);
  wire strobe_next = ~demux_eff ? ~strobe_reg :
                     ~ddr_eff   ? phase_reg :
                     pair_done  ? ~strobe_reg : strobe_reg;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      phase_reg  <= 1'b0;
      strobe_reg <= 1'b0;
      oe_reg     <= 1'b0;
      or_reg     <= 1'b0;
    end
    else
    begin
      oe_reg <= demux_eff;
      if (out_evt)
      begin
        phase_reg  <= demux_eff & ~phase_reg;
        strobe_reg <= strobe_next;
        or_reg     <= over_range;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      hold_i_reg  <= 8'h00;
      hold_q_reg  <= 8'h00;
      late_i_reg  <= 8'h00;
      late_q_reg  <= 8'h00;
      early_i_reg <= 8'h00;
      early_q_reg <= 8'h00;
    end
    else
    begin
      if (out_evt)
      begin
        hold_i_reg <= si_s2_reg;
        hold_q_reg <= sq_s2_reg;
      end
      if (word_upd)
      begin
        late_i_reg  <= si_s2_reg;
        late_q_reg  <= sq_s2_reg;
        early_i_reg <= hold_i_reg;
        early_q_reg <= hold_q_reg;
      end
    end
  end

  assign o_i_channel_late_bus    = late_i_reg;
  assign o_q_channel_late_bus    = late_q_reg;
  assign o_i_channel_early_bus   = early_i_reg;
  assign o_q_channel_early_bus   = early_q_reg;
  assign o_early_bus_oe          = oe_reg;
  assign o_forwarded_data_strobe = strobe_reg;
  assign o_mirror_data_strobe    = strobe_reg;
  assign o_out_of_range          = or_reg;

  // ----------------------------------------
  // Calibration sequence
  // ----------------------------------------
  logic [`AOD_CNT_W-1:0] cal_cnt_reg;
  logic                  first_done_reg;

  wire cal_last = (cal_cnt_reg == `AOD_CNT_W'(1));
  wire skip_trim = trim_skip_reg & first_done_reg;
  wire cal_end   = (cal_state_reg == AOD_CAL_CORE) & cal_last;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cal_state_reg  <= AOD_CAL_TRIM;
      cal_cnt_reg    <= `AOD_CNT_W'(`AOD_TRIM_CYCLES);
      first_done_reg <= 1'b0;
    end
    else
    begin
      case (cal_state_reg)
        AOD_CAL_IDLE:
          if (cal_go)
          begin
            cal_state_reg <= skip_trim ? AOD_CAL_CORE : AOD_CAL_TRIM;
            cal_cnt_reg   <= skip_trim ? `AOD_CNT_W'(`AOD_CORE_CYCLES) : `AOD_CNT_W'(`AOD_TRIM_CYCLES);
          end
        AOD_CAL_TRIM:
          if (cal_last)
          begin
            cal_state_reg <= AOD_CAL_CORE;
            cal_cnt_reg   <= `AOD_CNT_W'(`AOD_CORE_CYCLES);
          end
          else
            cal_cnt_reg <= cal_cnt_reg - `AOD_CNT_W'(1);
        AOD_CAL_CORE:
          if (cal_last)
          begin
            cal_state_reg  <= AOD_CAL_IDLE;
            first_done_reg <= 1'b1;
          end
          else
            cal_cnt_reg <= cal_cnt_reg - `AOD_CNT_W'(1);
        default:
          cal_state_reg <= AOD_CAL_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Register file and interrupt
  // ----------------------------------------
  logic or_d_reg;
  wire [`AOD_IRQ_W-1:0] irq_evt = {cal_end, or_reg & ~or_d_reg};
  wire [`AOD_DATA_W-1:0] state_word = {11'h000, ddr_eff, demux_eff, ext_active, trimming, calibrating};
  wire [`AOD_DATA_W-1:0] rdata_next =
    (i_reg_addr == `AOD_OFS_CTRL)     ? {14'h0000, ctrl_reg} :
    (i_reg_addr == `AOD_OFS_FSADJ)    ? {4'h0, fsadj_reg} :
    (i_reg_addr == `AOD_OFS_IRQ_STAT) ? {14'h0000, irq_stat_reg} :
    (i_reg_addr == `AOD_OFS_IRQ_MASK) ? {14'h0000, irq_mask_reg} :
    (i_reg_addr == `AOD_OFS_STATE)    ? state_word :
    (i_reg_addr == `AOD_OFS_EXT_CFG)  ? {15'h0000, trim_skip_reg} : 16'h0000;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_reg      <= `AOD_CTRL_RST;
      fsadj_reg     <= `AOD_FSADJ_RST;
      trim_skip_reg <= 1'b0;
      irq_mask_reg  <= 2'h0;
      irq_stat_reg  <= 2'h0;
      or_d_reg      <= 1'b0;
      rdata_reg     <= 16'h0000;
    end
    else
    begin
      or_d_reg  <= or_reg;
      rdata_reg <= i_reg_read ? rdata_next : 16'h0000;
      if (wr_ctrl)
        ctrl_reg <= i_reg_wdata[1:0];
      if (wr_fsadj)
        fsadj_reg <= i_reg_wdata[11:0];
      if (wr_mask)
        irq_mask_reg <= i_reg_wdata[1:0];
      if (wr_ext)
        trim_skip_reg <= i_reg_wdata[`AOD_EXT_TRIM_SKIP];
      irq_stat_reg <= (rd_stat ? 2'h0 : irq_stat_reg) | irq_evt;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_irq       = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [7:0] last_i_reg, cur_i_reg;
  logic       trim_seen_reg;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      last_i_reg    <= 8'h00;
      cur_i_reg     <= 8'h00;
      trim_seen_reg <= 1'b0;
    end
    else
    begin
      if (out_evt)
      begin
        last_i_reg <= cur_i_reg;
        cur_i_reg  <= si_s2_reg;
      end
      if (trimming)
        trim_seen_reg <= 1'b1;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  AST_EARLY_HIZ: assert property ($past(!demux_eff) |-> !o_early_bus_oe)
    else $error("Early bus driven in non-demux mode.");
  AST_MIRROR: assert property (o_mirror_data_strobe == o_forwarded_data_strobe)
    else $error("Mirror strobe differs from primary strobe.");
  AST_TRIM_FREEZE: assert property (trimming |=> $stable(o_forwarded_data_strobe))
    else $error("Strobe toggled during termination trim.");
  AST_FIRST_TRIM: assert property ($rose(first_done_reg) |-> trim_seen_reg)
    else $error("First calibration ended without a trim.");
  AST_SKIP_TRIM: assert property ((cal_state_reg == AOD_CAL_IDLE) && cal_go && trim_skip_reg && first_done_reg
    |=> cal_state_reg == AOD_CAL_CORE)
    else $error("Trim not skipped with trim-skip bit set.");
  AST_EARLY_PAIR: assert property (out_evt && pair_done |=> o_i_channel_early_bus == last_i_reg
    && o_i_channel_early_bus == $past(cur_i_reg) && o_i_channel_late_bus == $past(si_s2_reg))
    else $error("Early word is not the sample one input clock earlier.");
  AST_RANGE: assert property (out_evt |=> o_out_of_range == $past(over_range))
    else $error("Out-of-range flag does not follow the threshold.");
  AST_STROBE_LAUNCH: assert property ($changed(o_forwarded_data_strobe) |-> $past(out_evt))
    else $error("Strobe moved without a sample event.");
  AST_DDR_QUARTER: assert property ($changed(o_forwarded_data_strobe) && $past(demux_eff && ddr_eff)
    |-> $past(phase_reg) && $past(out_evt))
    else $error("Demux DDR strobe moved off a pair boundary.");

endmodule

// File: design/aod_defines.svh
// Offsets, field positions, reset values and timing counts of the output demultiplexer block.
`ifndef AOD_DEFINES_SVH
`define AOD_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AOD_ADDR_W          4
`define AOD_DATA_W          16
`define AOD_OFS_CTRL        4'h0
`define AOD_OFS_FSADJ       4'h1
`define AOD_OFS_IRQ_STAT    4'h2
`define AOD_OFS_IRQ_MASK    4'h3
`define AOD_OFS_STATE       4'h4
`define AOD_OFS_EXT_CFG     4'h9

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define AOD_CTRL_DEMUX_BIT  0
`define AOD_CTRL_DDR_BIT    1
`define AOD_CTRL_CAL_BIT    2
`define AOD_EXT_TRIM_SKIP   0
`define AOD_IRQ_RANGE_BIT   0
`define AOD_IRQ_CAL_BIT     1
`define AOD_IRQ_W           2
`define AOD_CTRL_RST        2'h1
`define AOD_FSADJ_RST       12'h366
`define AOD_FS_LOW_MV       12'h258
`define AOD_FS_HIGH_MV      12'h384

// ----------------------------------------
// Timing
// ----------------------------------------
`define AOD_CLK_PERIOD_NS   10
`define AOD_TRIM_TIME_NS    2000
`define AOD_CORE_TIME_NS    8000
`define AOD_TRIM_CYCLES     ((`AOD_TRIM_TIME_NS + `AOD_CLK_PERIOD_NS - 1) / `AOD_CLK_PERIOD_NS)
`define AOD_CORE_CYCLES     ((`AOD_CORE_TIME_NS + `AOD_CLK_PERIOD_NS - 1) / `AOD_CLK_PERIOD_NS)
`define AOD_CNT_W           12

`endif

// File: design/aod_pkg.sv
// Types of the output demultiplexer block.
package aod_pkg;

  // ----------------------------------------
  // Calibration sequence states
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    AOD_CAL_IDLE,
    AOD_CAL_TRIM,
    AOD_CAL_CORE
  } aod_cal_state_t;

endpackage

// File: bench/aod_capture_model.sv
// Receiver model that captures the late buses on each data strobe transition.
`timescale 1ns/1ns

module aod_capture_model
(
  input  wire logic        i_clk,
  input  wire logic        i_strobe,
  input  wire logic [7:0]  i_late_i,
  input  wire logic [7:0]  i_late_q,
  output logic      [15:0] o_word
);
  logic strobe_reg;

  // Words are taken on the i_clk edge after each strobe transition only, not on every clock.
  always_ff @(posedge i_clk)
  begin
    strobe_reg <= i_strobe;
    if (i_strobe !== strobe_reg)
    begin
      o_word <= {i_late_i, i_late_q};
    end
  end
endmodule

// File: bench/aod_output_demux_tb.sv
// Self-checking testbench of the output demultiplexer block.
`timescale 1ns/1ns
`include "aod_defines.svh"

module aod_output_demux_tb;
  logic                   i_clk, i_rst, sclk, sclk_q, dm, ddr, fsel, ext_n, calp, we, re;
  logic                   oe, stb, mir, oor, irq;
  logic [7:0]             si, sq, li, lq, ei, eq;
  logic signed [11:0]     lvl;
  logic [`AOD_ADDR_W-1:0] addr;
  logic [`AOD_DATA_W-1:0] wd, rdata, v;
  logic [15:0]            cap, cap_exp, hs[$];
  logic [3:0]             ra[4] = '{4'h0, 4'h1, 4'h3, 4'h5};
  logic [15:0]            rv[4] = '{16'h0001, 16'h0366, 16'h0000, 16'h0000};
  wire  [15:0]            e_pin = oe ? {ei, eq} : 16'hZZZZ;
  int                     fail_count, checked, seed, fs, m, hl[$];

  aod_output_demux i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_sample_clk(sclk), .i_sample_i(si),
    .i_sample_q(sq), .i_analog_level(lvl), .i_demux_mode_pin(dm), .i_ddr_mode_pin(ddr),
    .i_full_scale_select_pin(fsel), .i_ext_control_enable_pin_n(ext_n), .i_cal_request_pin(calp),
    .i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_write(we), .i_reg_read(re), .o_reg_rdata(rdata),
    .o_i_channel_late_bus(li), .o_q_channel_late_bus(lq), .o_i_channel_early_bus(ei),
    .o_q_channel_early_bus(eq), .o_early_bus_oe(oe), .o_forwarded_data_strobe(stb),
    .o_mirror_data_strobe(mir), .o_out_of_range(oor), .o_irq(irq));

  aod_capture_model i_rx (.i_clk(i_clk), .i_strobe(stb), .i_late_i(li), .i_late_q(lq), .o_word(cap));

  // --------------------------------
  // Clocks and sample stream
  // --------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial
  begin
    sclk = 1'b0;
    #3;
    forever #80 sclk = ~sclk;
  end

  always @(posedge i_clk)
  begin
    sclk_q <= sclk;
    if (sclk && !sclk_q)
    begin
      hs.push_back({si, sq});
      hl.push_back(lvl);
    end
    if (!sclk && sclk_q)
    begin
      si <= $random(seed);
      sq <= $random(seed);
      lvl <= $random(seed) % 700;
    end
    if (!i_rst)
      cmp(mir, stb);
  end

  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge i_clk);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clk);
    addr <= a;
    re <= 1'b1;
    @(posedge i_clk);
    re <= 1'b0;
    @(posedge i_clk);
    d = rdata;
  endtask

  task automatic max_still(input int n, output int mx);
    int run;
    logic p;
    mx = 0;
    run = 0;
    repeat (n)
    begin
      p = stb;
      @(posedge i_clk);
      run = (stb === p) ? run + 1 : 0;
      if (run > mx)
        mx = run;
    end
  endtask

  // Under extended control the pins are driven opposite to the mode expected.
  task automatic run_mode(input logic d, input logic r, input int n);
    int base, w, k, a;
    logic p;
    dm <= d ^ !ext_n;
    ddr <= r ^ !ext_n;
    repeat (60) @(posedge i_clk);
    base = 0;
    for (k = 0; k <= n; k++)
    begin
      w = 0;
      do
      begin
        p = stb;
        @(posedge i_clk);
        w++;
      end
      while (!(stb !== p && (stb || r || !d)) && w < 200);
      cmp(w < 200, 1'b1);
      if (k > 0)
      begin
        a = hl[$] < 0 ? -hl[$] : hl[$];
        cmp(16'(hs.size() - base), d ? 16'h0002 : 16'h0001);
        cmp({li, lq}, hs[$]);
        cmp(cap, cap_exp);
        cmp(oor, 2 * a > fs);
        cmp(oe, d);
        cmp(e_pin, d ? hs[$ - 1] : 16'hZZZZ);
      end
      base = hs.size();
      cap_exp = {li, lq};
    end
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // --------------------------------
  // Main sequence and watchdog
  // --------------------------------
  initial
  begin
    #500000;
    fail_count++;
    give_verdict;
  end

  initial
  begin
    seed = 9212;
    fs = 600;
    {i_rst, dm, ddr, fsel, ext_n, calp, we, re} <= 8'h88;
    {addr, wd, si, sq, lvl} <= '0;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    max_still(1100, m);
    cmp(m > 150, 1'b1);
    foreach (ra[i])
    begin
      rd(ra[i], v);
      cmp(v, rv[i]);
    end
    wr(4'hF, 16'hFFFF);
    rd(4'hF, v);
    cmp(v, 16'h0000);
    run_mode(1'b1, 1'b0, 12);
    fsel <= 1'b1;
    fs = 900;
    run_mode(1'b1, 1'b1, 12);
    run_mode(1'b0, 1'b1, 12);
    run_mode(1'b0, 1'b0, 12);
    ext_n <= 1'b0;
    fs = 500;
    wr(4'h1, 16'h01F4);
    wr(4'h0, 16'h0001);
    run_mode(1'b1, 1'b0, 12);
    wr(4'h3, 16'h0002);
    wr(4'h9, 16'h0001);
    rd(4'h9, v);
    cmp(v, 16'h0001);
    wr(4'h0, 16'h0007);
    max_still(1100, m);
    cmp(m < 60, 1'b1);
    cmp(irq, 1'b1);
    rd(4'h2, v);
    cmp(v & 16'h0002, 16'h0002);
    cmp(irq, 1'b0);
    wr(4'h9, 16'h0000);
    wr(4'h0, 16'h0007);
    max_still(1100, m);
    cmp(m > 150, 1'b1);
    ext_n <= 1'b1;
    calp <= 1'b1;
    repeat (5) @(posedge i_clk);
    calp <= 1'b0;
    max_still(1100, m);
    cmp(m > 150, 1'b1);
    give_verdict;
  end
endmodule
